/* File: src/lcds_params.svh */
`ifndef LCDS_PARAMS_SVH
`define LCDS_PARAMS_SVH

// Display memory geometry: 24 pages of 8 lines, 132 columns, 25,344 bits.
`define LCDS_COLS 132
`define LCDS_COMS 128
`define LCDS_PAGES 24
`define LCDS_PAGE_BITS 1056
`define LCDS_COL_MAX 8'h83
`define LCDS_PAGE_LIMIT 5'h18
`define LCDS_COL_LIMIT 8'h84
`define LCDS_LINE_WRAP 9'h0C0
`define LCDS_LINE_WRAP2 9'h180

// Reset values.
`define LCDS_COL_RST 8'h00
`define LCDS_START_RST 8'h00
`define LCDS_PAGE_RST 5'h00

// Status byte layout: busy indication on data bit 7.
`define LCDS_BUSY_BIT 7

`endif

/* File: src/lcds_pkg.sv */
package lcds_pkg;

    typedef enum logic [2:0] {
        OP_START_LINE = 3'h0,
        OP_PAGE_SET = 3'h1,
        OP_COLUMN_SET = 3'h2,
        OP_DATA_WRITE = 3'h3,
        OP_DATA_READ = 3'h4,
        OP_STATUS_READ = 3'h5
    } lcds_op_e;

    typedef enum logic [2:0] {
        LVL_VDD = 3'h0,
        LVL_V1 = 3'h1,
        LVL_V2 = 3'h2,
        LVL_V3 = 3'h3,
        LVL_V4 = 3'h4,
        LVL_V5 = 3'h5
    } lcds_lvl_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACCESS = 2'h1,
        ST_FINISH = 2'h3
    } lcds_state_e;

endpackage

/* File: src/lcds_display_memory.sv */
`timescale 1ns/1ps
`include "lcds_params.svh"

// Dual-port display memory: a byte port for the host and a whole-page port for
// the scan. Both ports work on their own, so host traffic never waits on refresh.
module lcds_display_memory (
    input wire logic ref_clk,
    input wire logic host_we,
    input wire logic host_re,
    input wire logic [4:0] host_page,
    input wire logic [7:0] host_col,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic [4:0] disp_page,
    output logic [`LCDS_PAGE_BITS-1:0] disp_word
);
    logic [`LCDS_PAGE_BITS-1:0] pages [0:`LCDS_PAGES-1];
    logic host_ok;
    logic disp_ok;
    logic [10:0] bit_base;

    always_comb begin
        host_ok = (host_page < `LCDS_PAGE_LIMIT) && (host_col < `LCDS_COL_LIMIT);
        disp_ok = (disp_page < `LCDS_PAGE_LIMIT);
        bit_base = {host_col, 3'h0};
    end

    always_ff @(posedge ref_clk) begin
        if (host_we && host_ok) begin
            pages[host_page][bit_base +: 8] <= host_wdata;
        end
        if (host_re) begin
            host_rdata <= host_ok ? pages[host_page][bit_base +: 8] : 8'h00;
        end
        disp_word <= disp_ok ? pages[disp_page] : '0;
    end
endmodule // lcds_display_memory

/* File: src/lcds_scan_top.sv */
`timescale 1ns/1ps
`include "lcds_params.svh"

module lcds_scan_top #(
    parameter bit COM_ORDER_B = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire lcds_pkg::lcds_op_e cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic reverse_display,
    input wire logic column_reverse,
    input wire logic alternation_signal,
    input wire logic common_cycle,
    output logic busy_indication,
    output logic status_valid,
    output logic [7:0] status_data,
    output logic read_valid,
    output logic [7:0] read_data,
    output logic [7:0] column_addr,
    output logic [4:0] page_addr,
    output logic [7:0] start_line,
    output logic [7:0] line_addr,
    output lcds_pkg::lcds_lvl_e [`LCDS_COLS-1:0] seg_level,
    output lcds_pkg::lcds_lvl_e [`LCDS_COMS-1:0] com_level
);
    // Synchronisers for the alternation signal and the common-cycle clock.
    logic alt_meta_q, alt_meta_d;
    logic alt_sync_q, alt_sync_d;
    logic alt_prev_q, alt_prev_d;
    logic cc_meta_q, cc_meta_d;
    logic cc_sync_q, cc_sync_d;
    logic cc_prev_q, cc_prev_d;
    logic alt_toggle;
    logic cc_rise;

    always_comb begin
        alt_meta_d = alternation_signal;
        alt_sync_d = alt_meta_q;
        alt_prev_d = alt_sync_q;
        cc_meta_d = common_cycle;
        cc_sync_d = cc_meta_q;
        cc_prev_d = cc_sync_q;
        alt_toggle = alt_sync_q ^ alt_prev_q;
        cc_rise = cc_sync_q & ~cc_prev_q;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_meta_q <= 1'b0;
            alt_sync_q <= 1'b0;
            alt_prev_q <= 1'b0;
            cc_meta_q <= 1'b0;
            cc_sync_q <= 1'b0;
            cc_prev_q <= 1'b0;
        end else begin
            alt_meta_q <= alt_meta_d;
            alt_sync_q <= alt_sync_d;
            alt_prev_q <= alt_prev_d;
            cc_meta_q <= cc_meta_d;
            cc_sync_q <= cc_sync_d;
            cc_prev_q <= cc_prev_d;
        end
    end

    // Host instruction execution.
    lcds_pkg::lcds_state_e state_q, state_d;
    logic busy_q, busy_d;
    logic op_read_q, op_read_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] column_q, column_d;
    logic [4:0] page_q, page_d;
    logic [7:0] start_q, start_d;
    logic status_valid_q, status_valid_d;
    logic [7:0] status_data_q, status_data_d;
    logic read_valid_q, read_valid_d;
    logic [7:0] read_data_q, read_data_d;
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_rdata;
    logic idle;

    always_comb begin
        state_d = state_q;
        op_read_d = op_read_q;
        wdata_d = wdata_q;
        column_d = column_q;
        page_d = page_q;
        start_d = start_q;
        status_valid_d = 1'b0;
        status_data_d = status_data_q;
        read_valid_d = 1'b0;
        read_data_d = read_data_q;
        idle = (state_q == lcds_pkg::ST_IDLE);
        mem_we = (state_q == lcds_pkg::ST_ACCESS) && !op_read_q;
        mem_re = (state_q == lcds_pkg::ST_ACCESS) && op_read_q;
        if (cmd_valid && cmd_op == lcds_pkg::OP_STATUS_READ) begin
            status_valid_d = 1'b1;
            status_data_d = 8'h00;
            status_data_d[`LCDS_BUSY_BIT] = busy_q;
        end else if (cmd_valid && idle) begin
            case (cmd_op)
                lcds_pkg::OP_START_LINE: begin
                    start_d = cmd_data;
                end
                lcds_pkg::OP_PAGE_SET: begin
                    page_d = cmd_data[4:0];
                end
                lcds_pkg::OP_COLUMN_SET: begin
                    column_d = cmd_data;
                end
                lcds_pkg::OP_DATA_WRITE: begin
                    state_d = lcds_pkg::ST_ACCESS;
                    op_read_d = 1'b0;
                    wdata_d = cmd_data;
                end
                lcds_pkg::OP_DATA_READ: begin
                    state_d = lcds_pkg::ST_ACCESS;
                    op_read_d = 1'b1;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
        case (state_q)
            lcds_pkg::ST_ACCESS: begin
                state_d = lcds_pkg::ST_FINISH;
            end
            lcds_pkg::ST_FINISH: begin
                state_d = lcds_pkg::ST_IDLE;
                read_valid_d = op_read_q;
                if (op_read_q) begin
                    read_data_d = mem_rdata;
                end
                // The page register is left alone here on purpose.
                if (column_q != `LCDS_COL_MAX) begin
                    column_d = column_q + 8'h01;
                end
            end
            default: begin
            end
        endcase
        busy_d = (state_d != lcds_pkg::ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= lcds_pkg::ST_IDLE;
            busy_q <= 1'b0;
            op_read_q <= 1'b0;
            wdata_q <= 8'h00;
            column_q <= `LCDS_COL_RST;
            page_q <= `LCDS_PAGE_RST;
            start_q <= `LCDS_START_RST;
            status_valid_q <= 1'b0;
            status_data_q <= 8'h00;
            read_valid_q <= 1'b0;
            read_data_q <= 8'h00;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            op_read_q <= op_read_d;
            wdata_q <= wdata_d;
            column_q <= column_d;
            page_q <= page_d;
            start_q <= start_d;
            status_valid_q <= status_valid_d;
            status_data_q <= status_data_d;
            read_valid_q <= read_valid_d;
            read_data_q <= read_data_d;
        end
    end

    // Display scan: line counter, readout address, latch and drivers.
    logic [7:0] line_cnt_q, line_cnt_d;
    logic step_q, step_d;
    logic latch_en_q, latch_en_d;
    logic [2:0] bit_sel_q, bit_sel_d;
    logic [6:0] scan_idx_q, scan_idx_d;
    logic [`LCDS_COLS-1:0] latch_q, latch_d;
    logic [7:0] line_addr_q, line_addr_d;
    lcds_pkg::lcds_lvl_e [`LCDS_COLS-1:0] seg_q, seg_d;
    lcds_pkg::lcds_lvl_e [`LCDS_COMS-1:0] com_q, com_d;
    logic [8:0] line_sum;
    logic [8:0] line_mod;
    logic [`LCDS_PAGE_BITS-1:0] disp_word;

    always_comb begin
        int col;
        int com;
        logic pix;
        col = 0;
        com = 0;
        pix = 1'b0;
        line_cnt_d = line_cnt_q;
        if (alt_toggle) begin
            line_cnt_d = 8'h00;
        end else if (cc_rise) begin
            line_cnt_d = line_cnt_q + 8'h01;
        end
        step_d = alt_toggle | cc_rise;
        latch_en_d = step_q;
        line_sum = {1'b0, start_q} + {1'b0, line_cnt_q};
        if (line_sum >= `LCDS_LINE_WRAP2) begin
            line_mod = line_sum - `LCDS_LINE_WRAP2;
        end else if (line_sum >= `LCDS_LINE_WRAP) begin
            line_mod = line_sum - `LCDS_LINE_WRAP;
        end else begin
            line_mod = line_sum;
        end
        line_addr_d = line_mod[7:0];
        bit_sel_d = line_addr_d[2:0];
        scan_idx_d = scan_idx_q;
        latch_d = latch_q;
        if (latch_en_q) begin
            scan_idx_d = line_cnt_q[6:0];
            for (int i = 0; i < `LCDS_COLS; i++) begin
                latch_d[i] = disp_word[i * 8 + int'(bit_sel_q)];
            end
        end
        for (int s = 0; s < `LCDS_COLS; s++) begin
            col = column_reverse ? (`LCDS_COLS - 1 - s) : s;
            pix = latch_q[col] ^ reverse_display;
            if (pix) begin
                seg_d[s] = alt_sync_q ? lcds_pkg::LVL_VDD : lcds_pkg::LVL_V5;
            end else begin
                seg_d[s] = alt_sync_q ? lcds_pkg::LVL_V2 : lcds_pkg::LVL_V3;
            end
        end
        for (int k = 0; k < `LCDS_COMS; k++) begin
            com = COM_ORDER_B ? (`LCDS_COMS - 1 - k) : k;
            if (7'(com) == scan_idx_q) begin
                com_d[k] = alt_sync_q ? lcds_pkg::LVL_V5 : lcds_pkg::LVL_VDD;
            end else begin
                com_d[k] = alt_sync_q ? lcds_pkg::LVL_V1 : lcds_pkg::LVL_V4;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_cnt_q <= 8'h00;
            step_q <= 1'b0;
            latch_en_q <= 1'b0;
            bit_sel_q <= 3'h0;
            scan_idx_q <= 7'h00;
            latch_q <= '0;
            line_addr_q <= 8'h00;
            seg_q <= '{default: lcds_pkg::LVL_V3};
            com_q <= '{default: lcds_pkg::LVL_V4};
        end else begin
            line_cnt_q <= line_cnt_d;
            step_q <= step_d;
            latch_en_q <= latch_en_d;
            bit_sel_q <= bit_sel_d;
            scan_idx_q <= scan_idx_d;
            latch_q <= latch_d;
            line_addr_q <= line_addr_d;
            seg_q <= seg_d;
            com_q <= com_d;
        end
    end

    // Host byte port and scan page port run side by side.
    lcds_display_memory u_mem (
        .ref_clk(ref_clk),
        .host_we(mem_we),
        .host_re(mem_re),
        .host_page(page_q),
        .host_col(column_q),
        .host_wdata(wdata_q),
        .host_rdata(mem_rdata),
        .disp_page(line_addr_d[7:3]),
        .disp_word(disp_word)
    );

    assign busy_indication = busy_q;
    assign status_valid = status_valid_q;
    assign status_data = status_data_q;
    assign read_valid = read_valid_q;
    assign read_data = read_data_q;
    assign column_addr = column_q;
    assign page_addr = page_q;
    assign start_line = start_q;
    assign line_addr = line_addr_q;
    assign seg_level = seg_q;
    assign com_level = com_q;
endmodule // lcds_scan_top

/* File: verification/lcds_scan_top_asserts.sv */
`timescale 1ns/1ps
module lcds_scan_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire lcds_pkg::lcds_op_e cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic busy_indication,
    input wire logic status_valid,
    input wire logic [7:0] status_data,
    input wire logic read_valid,
    input wire logic [7:0] column_addr,
    input wire logic [4:0] page_addr,
    input wire logic [7:0] start_line,
    input wire logic [7:0] line_addr
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic taken;
    logic data_taken;
    assign taken = cmd_valid && !busy_indication;
    assign data_taken = taken && cmd_op inside {lcds_pkg::OP_DATA_WRITE, lcds_pkg::OP_DATA_READ};
    sequence busy_run;
        busy_indication [*2] ##1 !busy_indication;
    endsequence
    sequence read_answer;
        !read_valid ##1 !read_valid ##1 read_valid;
    endsequence
    chk_busy_two: assert property (data_taken |=> busy_run)
        else $error("busy length wrong");
    chk_read_late: assert property (taken && cmd_op == lcds_pkg::OP_DATA_READ |=> read_answer)
        else $error("read answer misplaced");
    chk_status_bit: assert property (cmd_valid && cmd_op == lcds_pkg::OP_STATUS_READ |=>
        status_valid && status_data == {$past(busy_indication), 7'h00})
        else $error("status byte wrong");
    chk_col_step: assert property (data_taken && column_addr != 8'h83 |->
        ##3 column_addr == $past(column_addr, 3) + 8'h01)
        else $error("column did not step");
    chk_col_freeze: assert property (column_addr == 8'h83 &&
        !(taken && cmd_op == lcds_pkg::OP_COLUMN_SET) |=> column_addr == 8'h83)
        else $error("column left top");
    chk_page_hold: assert property (!(taken && cmd_op == lcds_pkg::OP_PAGE_SET) |=>
        $stable(page_addr))
        else $error("page moved");
    chk_page_load: assert property (taken && cmd_op == lcds_pkg::OP_PAGE_SET |=>
        {3'h0, page_addr} == ($past(cmd_data) & 8'h1F))
        else $error("page not loaded");
    chk_start_load: assert property (taken && cmd_op == lcds_pkg::OP_START_LINE |=>
        start_line == $past(cmd_data))
        else $error("start line not loaded");
    chk_line_wrap: assert property (line_addr < 8'hC0)
        else $error("line address beyond memory");
    chk_reset_vals: assert property ($fell(sys_rst) |-> column_addr == 8'h00 &&
        page_addr == 5'h00 && start_line == 8'h00)
        else $error("reset values wrong");
endmodule // lcds_scan_asserts
bind lcds_scan_top lcds_scan_asserts u_chk (.ref_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_data,
    .busy_indication, .status_valid, .status_data, .read_valid, .column_addr, .page_addr,
    .start_line, .line_addr);

/* File: verification/lcds_timing_model.sv */
`timescale 1ns/1ps
module lcds_timing_model #(
    parameter int FRAME = 8
) (
    input wire logic ref_clk,
    output logic alternation_signal,
    output logic common_cycle
);
    int rises = 0;
    initial begin
        alternation_signal = 1'b0;
        common_cycle = 1'b0;
    end
    // The line clock stands low between pulses; gap sets the pace and keeps rises apart.
    task automatic pulse(int gap);
        repeat (gap) @(posedge ref_clk);
        #1 common_cycle = 1'b1;
        repeat (gap) @(posedge ref_clk);
        #1 common_cycle = 1'b0;
        rises = rises + 1;
        if (rises == FRAME) begin
            repeat (4) @(posedge ref_clk);
            #1 alternation_signal = ~alternation_signal;
            rises = 0;
        end
    endtask
endmodule // lcds_timing_model

/* File: verification/tb_lcd_ram_addressing_and_scan.sv */
`timescale 1ns/1ps
module tb_lcd_ram_addressing_and_scan;
    logic ref_clk, sys_rst, cmd_valid, reverse_display, column_reverse;
    lcds_pkg::lcds_op_e cmd_op;
    logic [7:0] cmd_data, status_data, read_data, column_addr, start_line, line_addr;
    logic alternation_signal, common_cycle, busy_indication, status_valid, read_valid;
    logic [4:0] page_addr;
    lcds_pkg::lcds_lvl_e [131:0] seg_level;
    lcds_pkg::lcds_lvl_e [127:0] com_level;
    lcds_pkg::lcds_lvl_e [127:0] com_level_b;
    int miscompares = 0;
    int checks = 0;
    int seed = 95407;
    int pg, col, st, c;
    logic [7:0] mem [int];
    lcds_scan_top u_dut (.ref_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_data, .reverse_display,
        .column_reverse, .alternation_signal, .common_cycle, .busy_indication, .status_valid,
        .status_data, .read_valid, .read_data, .column_addr, .page_addr, .start_line,
        .line_addr, .seg_level, .com_level);
    // Second build variant with the reversed common scan order.
    lcds_scan_top #(.COM_ORDER_B(1'b1)) u_dut_b (.ref_clk, .sys_rst, .cmd_valid, .cmd_op,
        .cmd_data, .reverse_display, .column_reverse, .alternation_signal, .common_cycle,
        .busy_indication(), .status_valid(), .status_data(), .read_valid(), .read_data(),
        .column_addr(), .page_addr(), .start_line(), .line_addr(), .seg_level(),
        .com_level(com_level_b));
    lcds_timing_model u_tim (.ref_clk, .alternation_signal, .common_cycle);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (busy_indication !== 1'b0 && n < 8) begin
            tick();
            n++;
        end
        if (n == 8) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // Raises the strobe only; the caller lowers it, so back-to-back pulses stay legal.
    task automatic drive(lcds_pkg::lcds_op_e op, logic [7:0] d);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        tick();
    endtask
    task automatic issue(lcds_pkg::lcds_op_e op, logic [7:0] d);
        idle();
        drive(op, d);
        cmd_valid = 1'b0;
        tick();
    endtask
    task automatic setcol(int v);
        issue(lcds_pkg::OP_COLUMN_SET, v[7:0]);
        col = v;
    endtask
    task automatic setpg(int v);
        issue(lcds_pkg::OP_PAGE_SET, v[7:0]);
        pg = v;
    endtask
    task automatic wr(logic [7:0] d);
        issue(lcds_pkg::OP_DATA_WRITE, d);
        if (pg < 24 && col < 132) mem[pg * 132 + col] = d;
        if (col != 131) col = col + 1;
        idle();
        check("column", column_addr, col[7:0]);
    endtask
    task automatic rd();
        int n;
        n = 0;
        issue(lcds_pkg::OP_DATA_READ, 8'h00);
        while (read_valid !== 1'b1 && n < 4) begin
            tick();
            n++;
        end
        if (n == 4) begin
            miscompares++;
            tally_and_finish();
        end
        check("read", read_data, mem.exists(pg * 132 + col) ? mem[pg * 132 + col] : 8'h00);
        if (col != 131) col = col + 1;
        check("column", column_addr, col[7:0]);
    endtask
    task automatic scan(int gap);
        int l;
        logic on;
        logic a;
        logic [7:0] ce;
        u_tim.pulse(gap);
        repeat (10) tick();
        l = (st + u_tim.rises) % 192;
        a = alternation_signal;
        check("line", line_addr, l[7:0]);
        if (u_tim.rises != 0) begin
            for (int s = 0; s < 132; s++) begin
                on = mem[l / 8 * 132 + (column_reverse ? 131 - s : s)][l % 8] ^ reverse_display;
                check("seg", seg_level[s], a ? (on ? 8'h00 : 8'h02) : (on ? 8'h05 : 8'h03));
            end
            for (int k = 0; k < 128; k++) begin
                ce = (k == u_tim.rises) ? {7'h00, a} * 8'h05 : 8'h04 - 8'h03 * a;
                check("com", com_level[k], ce);
                check("com_b", com_level_b[127 - k], ce);
            end
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = lcds_pkg::OP_STATUS_READ;
        cmd_data = 8'h00;
        reverse_display = 1'b0;
        column_reverse = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        check("column", column_addr, 8'h00);
        check("start", start_line, 8'h00);
        check("page", {3'h0, page_addr}, 8'h00);
        tick();
        for (int p = 0; p < 2; p++) begin
            setpg(p);
            setcol(0);
            repeat (132) wr(8'($random(seed)));
        end
        setcol(8'h82);
        repeat (3) wr(8'hA5);
        setcol(8'h82);
        repeat (3) rd();
        idle();
        drive(lcds_pkg::OP_DATA_WRITE, 8'hC3);
        drive(lcds_pkg::OP_STATUS_READ, 8'h00);
        check("status", status_data, 8'h80);
        drive(lcds_pkg::OP_PAGE_SET, 8'h05);
        cmd_valid = 1'b0;
        mem[pg * 132 + col] = 8'hC3;
        tick();
        idle();
        check("page", {3'h0, page_addr}, pg[7:0]);
        issue(lcds_pkg::OP_STATUS_READ, 8'h00);
        check("status", status_data, 8'h00);
        for (int i = 0; i < 6; i++) begin
            setpg(($random(seed) & 32'hFF) % 25);
            c = ($random(seed) & 32'hFF) % 132;
            setcol(c);
            wr(8'($random(seed)));
            setcol(c);
            rd();
        end
        st = $random(seed) & 32'h7;
        issue(lcds_pkg::OP_START_LINE, st[7:0]);
        check("start", start_line, st[7:0]);
        for (int cfg = 0; cfg < 4; cfg++) begin
            reverse_display = cfg[0];
            column_reverse = cfg[1];
            repeat (3) scan(cfg[0] ? 7 : 2);
        end
        tally_and_finish();
    end
endmodule // tb_lcd_ram_addressing_and_scan
